// File: hw/cieec_top.sv
// Operation
// - A set enable bit passes its event flag as a request; clear blocks it.
// - Enable bit 5 gates the error condition request.
// - Enable bit 4 is absent: reads zero, writes ignored.
// - Enable bit 2 gates the receive buffer overflow request.
// - Enable bit 1 gates the receive buffer accepted message request.
// - Counter register bits 15-8 show transmit error count, read-only, zero at reset.
// - Counter register bits 7-0 show receive error count, read-only, zero at reset.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module cieec_top (
  // Clock and reset.
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  // AXI4-Lite write address.
  input  wire logic [cieec_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                           s_axi_awvalid_i,
  output logic                                s_axi_awready_o,
  // AXI4-Lite write data.
  input  wire logic [cieec_pkg::DATA_W-1:0]   s_axi_wdata_i,
  input  wire logic [cieec_pkg::DATA_W/8-1:0] s_axi_wstrb_i,
  input  wire logic                           s_axi_wvalid_i,
  output logic                                s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0]                          s_axi_bresp_o,
  output logic                                s_axi_bvalid_o,
  input  wire logic                           s_axi_bready_i,
  // AXI4-Lite read address.
  input  wire logic [cieec_pkg::ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                           s_axi_arvalid_i,
  output logic                                s_axi_arready_o,
  // AXI4-Lite read data.
  output logic [cieec_pkg::DATA_W-1:0]        s_axi_rdata_o,
  output logic [1:0]                          s_axi_rresp_o,
  output logic                                s_axi_rvalid_o,
  input  wire logic                           s_axi_rready_i,
  // Protocol engine side.
  input  wire logic [cieec_pkg::EVT_W-1:0]    event_flag_i,
  input  wire logic [cieec_pkg::CNT_W-1:0]    tx_error_count_i,
  input  wire logic [cieec_pkg::CNT_W-1:0]    rx_error_count_i,
  // Gated interrupt requests, one per enable bit position.
  output logic [cieec_pkg::EVT_W-1:0]         irq_req_o
);

  import cieec_pkg::*;

  // ==========================================================================
  // State.
  // ==========================================================================
  logic [EVT_W-1:0]  irq_enables;
  logic [CNT_W-1:0]  tx_error_count;
  logic [CNT_W-1:0]  rx_error_count;
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_held;
  logic [DATA_W-1:0] w_data;
  logic              w_strb0;

  logic [EVT_W-1:0]  next_irq_enables;
  logic [CNT_W-1:0]  next_tx_error_count;
  logic [CNT_W-1:0]  next_rx_error_count;
  logic              next_aw_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              next_w_held;
  logic [DATA_W-1:0] next_w_data;
  logic              next_w_strb0;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [1:0]        next_rresp;
  logic [DATA_W-1:0] next_rdata;

  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_strb0;

  assign aw_hs = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs  = s_axi_wvalid_i & s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;

  // ==========================================================================
  // Write channel: address and data are taken in either order.
  // ==========================================================================
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb0 = w_strb0;
    if (aw_hs) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (w_hs) begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata_i;
      next_w_strb0 = s_axi_wstrb_i[0];
    end
    wr_addr  = aw_hs ? s_axi_awaddr_i : aw_addr;
    wr_data  = w_hs ? s_axi_wdata_i : w_data;
    wr_strb0 = w_hs ? s_axi_wstrb_i[0] : w_strb0;
    commit   = next_aw_held & next_w_held;
    if (commit) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    next_bvalid = s_axi_bvalid_o & ~s_axi_bready_i;
    next_bresp  = s_axi_bresp_o;
    if (commit) begin
      next_bvalid = 1'b1;
      next_bresp  = (wr_addr == OFS_IRQ_ENABLES || wr_addr == OFS_ERR_COUNTS) ? RESP_OKAY : RESP_SLVERR;
    end
    // Ready drops while a response is pending, so a second write waits for it.
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
  end

  // ==========================================================================
  // Enable register. Only byte lane 0 holds writable bits.
  // ==========================================================================
  always_comb begin
    next_irq_enables = irq_enables;
    if (commit && wr_addr == OFS_IRQ_ENABLES && wr_strb0) begin
      // Bit 4 is masked so writes leave it zero; data bits above 5 are not taken.
      next_irq_enables = wr_data[EVT_W-1:0] & EN_IMPL_MASK;
    end
  end

  // ==========================================================================
  // Error counts are sampled each cycle so that reads see a clean snapshot.
  // ==========================================================================
  always_comb begin
    next_tx_error_count = tx_error_count_i;
    next_rx_error_count = rx_error_count_i;
  end

  // ==========================================================================
  // Read channel.
  // ==========================================================================
  always_comb begin
    next_rvalid  = s_axi_rvalid_o & ~s_axi_rready_i;
    next_rresp   = s_axi_rresp_o;
    next_rdata   = s_axi_rdata_o;
    if (ar_hs) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      unique case (s_axi_araddr_i)
        OFS_IRQ_ENABLES: begin
          next_rdata[EVT_W-1:0] = irq_enables;
        end
        OFS_ERR_COUNTS: begin
          next_rdata[TX_CNT_LSB +: CNT_W] = tx_error_count;
          next_rdata[RX_CNT_LSB +: CNT_W] = rx_error_count;
        end
        default: begin
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_enables     <= EN_RESET;
      tx_error_count  <= CNT_RESET;
      rx_error_count  <= CNT_RESET;
      aw_held         <= 1'b0;
      aw_addr         <= '0;
      w_held          <= 1'b0;
      w_data          <= '0;
      w_strb0         <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= RESP_OKAY;
      s_axi_rdata_o   <= '0;
    end else begin
      irq_enables     <= next_irq_enables;
      tx_error_count  <= next_tx_error_count;
      rx_error_count  <= next_rx_error_count;
      aw_held         <= next_aw_held;
      aw_addr         <= next_aw_addr;
      w_held          <= next_w_held;
      w_data          <= next_w_data;
      w_strb0         <= next_w_strb0;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o  <= next_wready;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rresp_o   <= next_rresp;
      s_axi_rdata_o   <= next_rdata;
    end
  end

  // ==========================================================================
  // Request gating.
  // ==========================================================================
  cieec_gate #(
    .WIDTH (EVT_W)
  ) u_gate (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .flag_i    (event_flag_i),
    .enable_i  (irq_enables),
    .req_o     (irq_req_o)
  );

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_REQ_FOLLOWS_ENABLE: assert property (
    ##1 irq_req_o == $past(event_flag_i & irq_enables))
    else $error("Interrupt request does not match gated flags");

  AST_ERROR_GATED: assert property (
    event_flag_i[BIT_ERROR] && !irq_enables[BIT_ERROR] |=> !irq_req_o[BIT_ERROR])
    else $error("Error request passed a cleared enable");

  AST_BIT4_ZERO: assert property (
    irq_enables[BIT_UNIMPL] == 1'b0 && irq_req_o[BIT_UNIMPL] == 1'b0)
    else $error("Unimplemented enable bit became set");

  AST_OVERFLOW_GATED: assert property (
    event_flag_i[BIT_RX_OVF] && irq_enables[BIT_RX_OVF] |=> irq_req_o[BIT_RX_OVF])
    else $error("Overflow request missing while enabled");

  AST_RX_BUF_WRITE: assert property (
    commit && wr_addr == OFS_IRQ_ENABLES && wr_strb0 |=> irq_enables[BIT_RX_BUF] == $past(wr_data[BIT_RX_BUF]))
    else $error("Receive buffer enable did not take the written value");

  AST_RX_BUF_GATED: assert property (
    1'b1 |=> irq_req_o[BIT_RX_BUF] == $past(event_flag_i[BIT_RX_BUF] & irq_enables[BIT_RX_BUF]))
    else $error("Receive buffer request does not follow its enable");

  AST_TX_COUNT_READ: assert property (
    ar_hs && s_axi_araddr_i == OFS_ERR_COUNTS
      |-> ##1 s_axi_rvalid_o && s_axi_rdata_o[TX_CNT_LSB +: CNT_W] == $past(tx_error_count, 1))
    else $error("Transmit error count read wrong");

  AST_RX_COUNT_READ: assert property (
    ar_hs && s_axi_araddr_i == OFS_ERR_COUNTS
      |-> ##1 s_axi_rdata_o[RX_CNT_LSB +: CNT_W] == $past(rx_error_count) && s_axi_rdata_o[31:16] == '0)
    else $error("Receive error count read wrong");

  AST_FIFO_TX_GATED: assert property (
    !irq_enables[BIT_FIFO_AF] && !irq_enables[BIT_TX_BUF]
      |=> !irq_req_o[BIT_FIFO_AF] && !irq_req_o[BIT_TX_BUF])
    else $error("FIFO or transmit request passed a cleared enable");

  AST_WRITE_RESP_HOLDS: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("Write response dropped before it was taken");

endmodule : cieec_top

// File: hw/cieec_pkg.sv
package cieec_pkg;

  // ==========================================================================
  // Bus geometry.
  // ==========================================================================
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 16;
  localparam int          EVT_W           = 6;
  localparam int          CNT_W           = 8;

  // ==========================================================================
  // Register byte offsets.
  // ==========================================================================
  localparam logic [3:0]  OFS_IRQ_ENABLES = 4'h0;
  localparam logic [3:0]  OFS_ERR_COUNTS  = 4'h4;

  // ==========================================================================
  // Enable register bit positions.
  // ==========================================================================
  localparam int          BIT_TX_BUF      = 0;
  localparam int          BIT_RX_BUF      = 1;
  localparam int          BIT_RX_OVF      = 2;
  localparam int          BIT_FIFO_AF     = 3;
  localparam int          BIT_UNIMPL      = 4;
  localparam int          BIT_ERROR       = 5;

  // Writable bits of the enable register: 5, 3, 2, 1 and 0.
  localparam logic [5:0]  EN_IMPL_MASK    = 6'h2F;
  localparam logic [5:0]  EN_RESET        = 6'h00;
  localparam logic [7:0]  CNT_RESET       = 8'h00;

  // ==========================================================================
  // Error counter register field positions.
  // ==========================================================================
  localparam int          TX_CNT_LSB      = 8;
  localparam int          RX_CNT_LSB      = 0;

  // ==========================================================================
  // AXI4-Lite response codes.
  // ==========================================================================
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : cieec_pkg

// File: hw/cieec_gate.sv
`timescale 1ns/1ns
module cieec_gate
  import cieec_pkg::*;
#(
  parameter int WIDTH = cieec_pkg::EVT_W
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Event flags and enables.
  input  wire logic [WIDTH-1:0] flag_i,
  input  wire logic [WIDTH-1:0] enable_i,
  // Gated requests.
  output logic      [WIDTH-1:0] req_o
);

  logic [WIDTH-1:0] next_req;

  // A zero-width gate has nothing to serve, so elaboration stops here.
  if (WIDTH < 1) begin : g_bad_width
    $error("cieec_gate needs at least one event");
  end

  // ==========================================================================
  // One gate per event; a cleared enable blocks its request.
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_gate
      always_comb begin
        next_req[i] = flag_i[i] & enable_i[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_o <= '0;
    end else begin
      req_o <= next_req;
    end
  end

endmodule : cieec_gate

// File: tb/cieec_engine_model.sv
`timescale 1ns/1ns
// ============================================================================
// Protocol engine stand-in: holds event flags and error counts.
// ============================================================================
module cieec_engine_model (
  // Clock and reset.
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  // Settings from the bench.
  input  wire logic [cieec_pkg::EVT_W-1:0] set_flag_i,
  input  wire logic [cieec_pkg::CNT_W-1:0] set_tx_i,
  input  wire logic [cieec_pkg::CNT_W-1:0] set_rx_i,
  // Toward the block.
  output logic      [cieec_pkg::EVT_W-1:0] event_flag_o,
  output logic      [cieec_pkg::CNT_W-1:0] tx_error_count_o,
  output logic      [cieec_pkg::CNT_W-1:0] rx_error_count_o
);
  import cieec_pkg::*;

  logic [EVT_W-1:0] next_flag;
  logic [CNT_W-1:0] next_tx;
  logic [CNT_W-1:0] next_rx;

  // Values are registered so they change one edge after the bench asks, like a real engine.
  always_comb begin
    next_flag = sys_rst_i ? '0 : set_flag_i;
    next_tx   = sys_rst_i ? '0 : set_tx_i;
    next_rx   = sys_rst_i ? '0 : set_rx_i;
  end

  always_ff @(posedge clk_i) begin
    event_flag_o     <= next_flag;
    tx_error_count_o <= next_tx;
    rx_error_count_o <= next_rx;
  end
endmodule : cieec_engine_model

// File: tb/cieec_top_tb.sv
`timescale 1ns/1ns
module cieec_top_tb;
  import cieec_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

  logic                clk_i, sys_rst_i;
  logic [ADDR_W-1:0]   s_axi_awaddr_i, s_axi_araddr_i;
  logic [DATA_W-1:0]   s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]          s_axi_wstrb_i;
  logic [1:0]          s_axi_bresp_o, s_axi_rresp_o;
  logic                s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic                s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [EVT_W-1:0]    event_flag_i, irq_req_o, cmd_flag;
  logic [CNT_W-1:0]    tx_error_count_i, rx_error_count_i, cmd_tx, cmd_rx;
  int                  n_fail, checks_done;

  cieec_top i_dut (.clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .event_flag_i, .tx_error_count_i, .rx_error_count_i, .irq_req_o);

  cieec_engine_model i_engine (.clk_i, .sys_rst_i, .set_flag_i(cmd_flag), .set_tx_i(cmd_tx), .set_rx_i(cmd_rx),
    .event_flag_o(event_flag_i), .tx_error_count_o(tx_error_count_i), .rx_error_count_o(rx_error_count_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Every call starts on a fresh edge so no signal is assigned twice in one time step.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_wstrb_i   <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1) break;
    end
    s_axi_bready_i <= 1'b0;
    if (n == 50) begin
      n_fail++;
      print_verdict();
    end else begin
      `CHK(s_axi_bresp_o, er)
    end
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1) break;
    end
    s_axi_rready_i <= 1'b0;
    if (n == 50) begin
      n_fail++;
      print_verdict();
    end else begin
      `CHK(s_axi_rdata_o, ed)
      `CHK(s_axi_rresp_o, er)
    end
  endtask : axi_read

  initial begin
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {cmd_flag, cmd_tx, cmd_rx} = '0;
    n_fail      = 0;
    checks_done = 0;
    sys_rst_i   = 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    axi_read(OFS_IRQ_ENABLES, 32'h0000_0000, RESP_OKAY);
    axi_read(OFS_ERR_COUNTS, 32'h0000_0000, RESP_OKAY);
    axi_write(OFS_IRQ_ENABLES, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axi_read(OFS_IRQ_ENABLES, 32'h0000_002F, RESP_OKAY);
    // One enable at a time with every flag up: only that bit may request.
    cmd_flag <= 6'h3F;
    for (int i = 0; i < EVT_W; i++) begin
      axi_write(OFS_IRQ_ENABLES, 32'h0000_0001 << i, 4'h1, RESP_OKAY);
      repeat (3) @(posedge clk_i);
      #1 `CHK(irq_req_o, (6'h01 << i) & 6'h2F)
      axi_read(OFS_IRQ_ENABLES, (32'h0000_0001 << i) & 32'h0000_002F, RESP_OKAY);
    end
    // All enables set, one flag at a time.
    axi_write(OFS_IRQ_ENABLES, 32'h0000_003F, 4'h1, RESP_OKAY);
    for (int i = 0; i <= EVT_W; i++) begin
      cmd_flag <= (i < EVT_W) ? (6'h01 << i) : 6'h00;
      repeat (3) @(posedge clk_i);
      #1 `CHK(irq_req_o, (i < EVT_W) ? ((6'h01 << i) & 6'h2F) : 6'h00)
    end
    axi_write(OFS_IRQ_ENABLES, 32'h0000_0000, 4'h0, RESP_OKAY);
    axi_read(OFS_IRQ_ENABLES, 32'h0000_002F, RESP_OKAY);
    cmd_tx <= 8'hA5;
    cmd_rx <= 8'h3C;
    repeat (2) @(posedge clk_i);
    axi_read(OFS_ERR_COUNTS, 32'h0000_A53C, RESP_OKAY);
    axi_write(OFS_ERR_COUNTS, 32'h0000_0000, 4'hF, RESP_OKAY);
    axi_read(OFS_ERR_COUNTS, 32'h0000_A53C, RESP_OKAY);
    axi_write(4'h8, 32'h0000_0000, 4'hF, RESP_SLVERR);
    axi_read(4'h8, 32'h0000_0000, RESP_SLVERR);
    axi_read(OFS_IRQ_ENABLES, 32'h0000_002F, RESP_OKAY);
    print_verdict();
  end
endmodule : cieec_top_tb
